// File: hw/smwd_decode.sv
// Management-memory and graphics window decoder with Avalon-MM registers.
// Assumes requests come from same-clock logic and are decoded one per cycle.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "smwd_params.svh"
module smwd_decode #(
    parameter int CTRL_WIN_MB = 1,
    parameter int APERTURE_MB = 256,
    parameter int XLATE_MB = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clkEnable,
    input wire logic [4:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [31:0] avWritedata,
    input wire logic [3:0] avByteenable,
    output logic [31:0] avReaddata,
    output logic avWaitrequest,
    input wire logic reqValid,
    input wire smwd_pkg::smwd_source_t reqSource,
    input wire logic [31:0] reqAddr,
    input wire logic reqWrite,
    input wire logic reqCodeFetch,
    input wire logic reqMgmtMode,
    input wire logic reqTypeBit1,
    input wire logic reqTranslated,
    input wire logic reqTableFetch,
    input wire logic reqTiled,
    output logic decValid,
    output smwd_pkg::smwd_target_t decTarget,
    output logic [31:0] decAddr,
    output logic decByteEnOff,
    output logic decUnsupported,
    output logic decViolation
);
    import smwd_pkg::*;

    logic [31:0] ctrl;
    logic [11:0] lowTop;
    logic [11:0] stolen;
    logic [11:0] ctrlWinBase;
    logic [11:0] apertureBase;
    logic [11:0] xlateBase;
    logic [31:0] shadowMask;
    logic violFlag;

    logic wrTake;
    logic [31:0] rdValue;
    logic [31:0] ctrlMerged;
    logic [31:0] ctrlMask;
    logic [31:0] wrMerged;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : mergeBytes

    // Bus slave: one wait cycle, then the answer for a single cycle
    assign wrTake = avWrite && !avWaitrequest;
    assign ctrlMerged = mergeBytes(ctrl, avWritedata, avByteenable);
    // Merging against the addressed register keeps unselected byte lanes intact
    assign wrMerged = mergeBytes(rdValue, avWritedata, avByteenable);
    assign ctrlMask = ctrl[`SMWD_BIT_LOCK] ? `SMWD_CTRL_LOCKED_WMASK : `SMWD_CTRL_WMASK;

    always_comb begin
        case (avAddress)
            `SMWD_OFS_CTRL: rdValue = ctrl;
            `SMWD_OFS_LOWTOP: rdValue = {20'h0_0000, lowTop};
            `SMWD_OFS_STOLEN: rdValue = {20'h0_0000, stolen};
            `SMWD_OFS_CTRLWIN: rdValue = {20'h0_0000, ctrlWinBase};
            `SMWD_OFS_APERTURE: rdValue = {20'h0_0000, apertureBase};
            `SMWD_OFS_XLATE: rdValue = {20'h0_0000, xlateBase};
            `SMWD_OFS_SHADOW: rdValue = shadowMask;
            `SMWD_OFS_STATUS: rdValue = {31'h0000_0000, violFlag};
            default: rdValue = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avWaitrequest <= 1'b1;
            avReaddata <= 32'h0000_0000;
        end else if (clkEnable) begin
            if ((avRead || avWrite) && avWaitrequest) begin
                avWaitrequest <= 1'b0;
                avReaddata <= rdValue;
            end else begin
                avWaitrequest <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl <= `SMWD_CTRL_RESET;
            lowTop <= `SMWD_LOWTOP_RESET;
            stolen <= `SMWD_STOLEN_RESET;
            ctrlWinBase <= `SMWD_CTRLWIN_RESET;
            apertureBase <= `SMWD_APERTURE_RESET;
            xlateBase <= `SMWD_XLATE_RESET;
            shadowMask <= `SMWD_SHADOW_RESET;
        end else if (clkEnable && wrTake) begin
            case (avAddress)
                // Once locked only close and forwarding bits move; lock holds until reset
                `SMWD_OFS_CTRL: ctrl <= ((ctrlMerged & ctrlMask) | (ctrl & ~ctrlMask));
                `SMWD_OFS_LOWTOP: lowTop <= ctrl[`SMWD_BIT_LOCK] ? lowTop : wrMerged[11:0];
                `SMWD_OFS_STOLEN: stolen <= ctrl[`SMWD_BIT_LOCK] ? stolen : wrMerged[11:0];
                `SMWD_OFS_CTRLWIN: ctrlWinBase <= wrMerged[11:0];
                `SMWD_OFS_APERTURE: apertureBase <= wrMerged[11:0];
                `SMWD_OFS_XLATE: xlateBase <= wrMerged[11:0];
                `SMWD_OFS_SHADOW: shadowMask <= wrMerged;
                default: ;
            endcase
        end
    end

    // Control fields
    logic gme, tEn, cEn, hEn, openEff, closeBit, lockBit, vgaFwd, monoPresent;
    logic [11:0] segMb, segTop, segBase, mb;
    assign gme = ctrl[`SMWD_BIT_GME];
    assign cEn = gme && !ctrl[`SMWD_BIT_HRE];
    assign hEn = gme && ctrl[`SMWD_BIT_HRE];
    assign tEn = gme && ctrl[`SMWD_BIT_TSE];
    assign lockBit = ctrl[`SMWD_BIT_LOCK];
    assign openEff = ctrl[`SMWD_BIT_OPEN] && !lockBit;
    assign closeBit = ctrl[`SMWD_BIT_CLOSE];
    assign vgaFwd = ctrl[`SMWD_BIT_VGA];
    assign monoPresent = ctrl[`SMWD_BIT_MONO];
    assign segMb = (ctrl[`SMWD_BIT_SEGSZ +: 2] == `SMWD_SEG_CODE_8MB) ? `SMWD_SEG_8MB :
                   (ctrl[`SMWD_BIT_SEGSZ +: 2] == `SMWD_SEG_CODE_2MB) ? `SMWD_SEG_2MB :
                   `SMWD_SEG_1MB;
    assign segTop = lowTop - stolen;
    assign segBase = segTop - segMb;
    assign mb = reqAddr[31:20];

    // Address classification
    logic inLegacy, inHigh, inMono, inShadow, inLowRegion, tHit, cHit, hHit;
    logic ctrlWinHit, apertureHit, xlateHit, shadowToDram, isCpu, physMgmt, fetchBad, wbCycle;
    assign inLegacy = reqAddr[31:17] == `SMWD_LEGACY_TAG;
    assign inHigh = reqAddr[31:17] == `SMWD_HIGH_TAG;
    assign inMono = reqAddr[31:15] == `SMWD_MONO_TAG;
    assign inShadow = reqAddr[31:18] == `SMWD_SHADOW_TAG;
    assign inLowRegion = (mb == 12'h000) && (reqAddr[19:17] >= `SMWD_LOWREGION_LO);
    assign cHit = cEn && inLegacy;
    assign hHit = hEn && inHigh;
    assign isCpu = reqSource == SMWD_SRC_CPU;
    assign wbCycle = !reqTypeBit1;
    // Enabled management DRAM as seen after translation; high range lands on legacy DRAM
    assign physMgmt = (gme && inLegacy) || tHit;
    assign fetchBad = (mb >= segBase) || inLowRegion;

    smwd_range_match #(.W(12)) segMatch (
        .addr(mb), .lo(segBase), .hi(segTop), .en(tEn), .hit(tHit)
    );
    smwd_range_match #(.W(12)) ctrlWinMatch (
        .addr(mb), .lo(ctrlWinBase), .hi(ctrlWinBase + 12'(CTRL_WIN_MB)), .en(1'b1),
        .hit(ctrlWinHit)
    );
    smwd_range_match #(.W(12)) apertureMatch (
        .addr(mb), .lo(apertureBase), .hi(apertureBase + 12'(APERTURE_MB)), .en(1'b1),
        .hit(apertureHit)
    );
    smwd_range_match #(.W(12)) xlateMatch (
        .addr(mb), .lo(xlateBase), .hi(xlateBase + 12'(XLATE_MB)), .en(1'b1),
        .hit(xlateHit)
    );
    smwd_shadow_sel #(.BLOCKS(16)) shadowSel (
        .block(reqAddr[17:14]), .readToDram(shadowMask[15:0]),
        .writeToDram(shadowMask[31:16]), .isWrite(reqWrite), .toDram(shadowToDram)
    );

    smwd_target_t next_target, vgaTarget;
    logic [31:0] next_addr;
    logic next_beOff, next_ur, next_viol;
    // A mono adapter keeps its own slice of the legacy range on the south bridge
    assign vgaTarget = (vgaFwd && !(monoPresent && inMono)) ? SMWD_TGT_GFXLINK
                                                           : SMWD_TGT_SBLINK;

    always_comb begin
        next_target = SMWD_TGT_SBLINK;
        next_addr = reqAddr;
        next_beOff = 1'b0;
        next_ur = 1'b0;
        next_viol = 1'b0;
        if (reqTableFetch) begin
            next_target = SMWD_TGT_DRAM;
            if (fetchBad) begin
                next_addr = `SMWD_REDIRECT_ADDR;
            end
        end else if (reqTranslated) begin
            next_target = SMWD_TGT_DRAM;
            if (physMgmt) begin
                next_addr = `SMWD_REDIRECT_ADDR;
                next_beOff = reqWrite;
                next_viol = 1'b1;
            end
        end else if (!isCpu && apertureHit) begin
            if (!reqWrite) begin
                next_target = SMWD_TGT_DRAM;
                next_addr = `SMWD_REDIRECT_ADDR;
                next_ur = 1'b1;
            end else if (reqTiled) begin
                // Tiled link writes are unsupported, so they are swallowed harmlessly
                next_target = SMWD_TGT_DRAM;
                next_addr = `SMWD_REDIRECT_ADDR;
                next_beOff = 1'b1;
            end else begin
                next_target = SMWD_TGT_GFX;
            end
        end else if (!isCpu && (cHit || hHit || tHit)) begin
            next_target = SMWD_TGT_ABORT;
            next_ur = 1'b1;
        end else if (isCpu && (cHit || hHit || tHit)) begin
            if (closeBit && reqMgmtMode && !reqCodeFetch && !hHit) begin
                next_target = tHit ? SMWD_TGT_SBLINK : vgaTarget;
            end else if (reqMgmtMode || openEff || wbCycle) begin
                // Writebacks must land to keep cached management memory coherent
                next_target = SMWD_TGT_DRAM;
                if (hHit) begin
                    next_addr = {`SMWD_LEGACY_TAG, reqAddr[16:0]};
                end
            end else if (cHit) begin
                next_target = vgaTarget;
            end else begin
                next_target = SMWD_TGT_ABORT;
            end
        end else if (ctrlWinHit || apertureHit || xlateHit) begin
            // Windows are checked before DRAM since they sit above low DRAM top
            next_target = SMWD_TGT_GFX;
        end else if (inLegacy) begin
            next_target = vgaTarget;
        end else if (inShadow) begin
            next_target = shadowToDram ? SMWD_TGT_DRAM : SMWD_TGT_SBLINK;
        end else if (mb < lowTop) begin
            next_target = SMWD_TGT_DRAM;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            decValid <= 1'b0;
            decTarget <= SMWD_TGT_SBLINK;
            decAddr <= 32'h0000_0000;
            decByteEnOff <= 1'b0;
            decUnsupported <= 1'b0;
            decViolation <= 1'b0;
        end else if (clkEnable) begin
            decValid <= reqValid;
            decViolation <= reqValid && next_viol;
            if (reqValid) begin
                decTarget <= next_target;
                decAddr <= next_addr;
                decByteEnOff <= next_beOff;
                decUnsupported <= next_ur;
            end
        end
    end

    // Set beats a same-cycle write-one clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            violFlag <= 1'b0;
        end else if (clkEnable) begin
            if (reqValid && next_viol) begin
                violFlag <= 1'b1;
            end else if (wrTake && avAddress == `SMWD_OFS_STATUS && avByteenable[0] &&
                         avWritedata[`SMWD_BIT_VIOL]) begin
                violFlag <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic plainCpu;
    assign plainCpu = reqValid && clkEnable && isCpu && !reqTableFetch && !reqTranslated;

    legacy_identity_a: assert property (plainCpu && cHit && reqMgmtMode && !closeBit
        |=> decTarget == SMWD_TGT_DRAM && decAddr == $past(reqAddr))
        else $error("legacy range not decoded to same DRAM address");
    high_remap_a: assert property (plainCpu && hHit && reqMgmtMode
        |=> decTarget == SMWD_TGT_DRAM && decAddr[31:17] == 15'h0005 &&
            decAddr[16:0] == $past(reqAddr[16:0]))
        else $error("high range not remapped onto legacy DRAM");
    global_off_a: assert property (plainCpu && !gme && inHigh
        |=> decTarget != SMWD_TGT_DRAM)
        else $error("high range decoded to DRAM with global enable off");
    link_block_a: assert property (reqValid && clkEnable && !isCpu && !reqTableFetch &&
        !reqTranslated && !apertureHit && (cHit || tHit)
        |=> decTarget == SMWD_TGT_ABORT && decUnsupported)
        else $error("link request reached management memory");
    open_access_a: assert property (plainCpu && tHit && !reqMgmtMode && openEff
        && !closeBit |=> decTarget == SMWD_TGT_DRAM)
        else $error("open bit did not grant access");
    lock_block_a: assert property (plainCpu && tHit && lockBit && !reqMgmtMode &&
        reqTypeBit1 |=> decTarget == SMWD_TGT_ABORT)
        else $error("locked segment reached outside management mode");
    close_fwd_a: assert property (plainCpu && tHit && closeBit && reqMgmtMode &&
        !reqCodeFetch |=> decTarget == SMWD_TGT_SBLINK)
        else $error("closed segment data access not forwarded");
    wb_commit_a: assert property (plainCpu && (cHit || tHit) && !reqTypeBit1 &&
        !closeBit |=> decTarget == SMWD_TGT_DRAM)
        else $error("writeback not committed to management DRAM");
    xlate_redirect_a: assert property (reqValid && clkEnable && !reqTableFetch &&
        reqTranslated && physMgmt && reqWrite
        |=> decAddr == `SMWD_REDIRECT_ADDR && decByteEnOff && decViolation)
        else $error("translated management hit not redirected");
    aperture_read_a: assert property (reqValid && clkEnable && !isCpu && !reqWrite &&
        !reqTableFetch && !reqTranslated && apertureHit
        |=> decAddr == `SMWD_REDIRECT_ADDR && decUnsupported)
        else $error("link aperture read not redirected with UR");
    sticky_flag_a: assert property (violFlag && !wrTake ##1 clkEnable
        |-> violFlag)
        else $error("violation flag dropped without a clear");

    hit_high_c: cover property (plainCpu && hHit && reqMgmtMode);
    hit_violation_c: cover property (decViolation ##1 violFlag);
    hit_shadow_c: cover property (plainCpu && inShadow && reqWrite && shadowToDram);
    hit_close_c: cover property (plainCpu && tHit && closeBit && reqCodeFetch);
endmodule : smwd_decode
`default_nettype wire

// File: include/smwd_params.svh
// Constants for the management-memory window decoder: register offsets,
// field positions, reset values and fixed address tags.
// Assumes a 32-bit processor address and 1 MB granularity for window bases.
`ifndef SMWD_PARAMS_SVH
`define SMWD_PARAMS_SVH

`define SMWD_OFS_CTRL 5'h00
`define SMWD_OFS_LOWTOP 5'h04
`define SMWD_OFS_STOLEN 5'h08
`define SMWD_OFS_CTRLWIN 5'h0C
`define SMWD_OFS_APERTURE 5'h10
`define SMWD_OFS_XLATE 5'h14
`define SMWD_OFS_SHADOW 5'h18
`define SMWD_OFS_STATUS 5'h1C

`define SMWD_BIT_GME 0
`define SMWD_BIT_HRE 1
`define SMWD_BIT_TSE 2
`define SMWD_BIT_OPEN 3
`define SMWD_BIT_CLOSE 4
`define SMWD_BIT_LOCK 5
`define SMWD_BIT_VGA 6
`define SMWD_BIT_MONO 7
`define SMWD_BIT_SEGSZ 8
`define SMWD_BIT_VIOL 0

`define SMWD_CTRL_WMASK 32'h0000_03FF
`define SMWD_CTRL_LOCKED_WMASK 32'h0000_00D0

`define SMWD_CTRL_RESET 32'h0000_0000
`define SMWD_LOWTOP_RESET 12'h040
`define SMWD_STOLEN_RESET 12'h001
`define SMWD_CTRLWIN_RESET 12'hE00
`define SMWD_APERTURE_RESET 12'hD00
`define SMWD_XLATE_RESET 12'hE01
`define SMWD_SHADOW_RESET 32'h0000_0000

`define SMWD_SEG_CODE_2MB 2'h1
`define SMWD_SEG_CODE_8MB 2'h2
`define SMWD_SEG_1MB 12'h001
`define SMWD_SEG_2MB 12'h002
`define SMWD_SEG_8MB 12'h008

`define SMWD_LEGACY_TAG 15'h0005
`define SMWD_HIGH_TAG 15'h7F6D
`define SMWD_MONO_TAG 17'h0_0016
`define SMWD_SHADOW_TAG 14'h0003
`define SMWD_LOWREGION_LO 3'h5
`define SMWD_REDIRECT_ADDR 32'h000C_0000

`endif

// File: include/smwd_pkg.sv
// Types shared by the management-memory window decoder.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package smwd_pkg;
    typedef enum logic [2:0] {
        SMWD_TGT_DRAM,
        SMWD_TGT_GFX,
        SMWD_TGT_GFXLINK,
        SMWD_TGT_SBLINK,
        SMWD_TGT_ABORT
    } smwd_target_t;

    typedef enum logic [1:0] {
        SMWD_SRC_CPU,
        SMWD_SRC_GFXLINK,
        SMWD_SRC_SBLINK,
        SMWD_SRC_GFXENGINE
    } smwd_source_t;
endpackage : smwd_pkg
`default_nettype wire

// File: hw/smwd_range_match.sv
// Half-open range comparator on megabyte-granular address tags.
// Assumes hi does not wrap past the top of the tag width.
`timescale 1ns/1ps
`default_nettype none
module smwd_range_match #(
    parameter int W = 12
) (
    input wire logic [W-1:0] addr,
    input wire logic [W-1:0] lo,
    input wire logic [W-1:0] hi,
    input wire logic en,
    output logic hit
);
    assign hit = en && (addr >= lo) && (addr < hi);
endmodule : smwd_range_match
`default_nettype wire

// File: hw/smwd_shadow_sel.sv
// Shadow block steering: one read bit and one write bit per 16 KB block.
// Assumes the caller already checked the address lies in the shadow region.
`timescale 1ns/1ps
`default_nettype none
module smwd_shadow_sel #(
    parameter int BLOCKS = 16
) (
    input wire logic [$clog2(BLOCKS)-1:0] block,
    input wire logic [BLOCKS-1:0] readToDram,
    input wire logic [BLOCKS-1:0] writeToDram,
    input wire logic isWrite,
    output logic toDram
);
    // Reads and writes steer independently so ROM can be copied in place
    assign toDram = isWrite ? writeToDram[block] : readToDram[block];
endmodule : smwd_shadow_sel
`default_nettype wire

// File: tb/smwd_req_model.sv
// Requester model: processor, link and graphics-engine masters issuing decode requests.
// Assumes the decoder takes a request at the edge after it is driven.
`timescale 1ns/1ps
`default_nettype none
module smwd_req_model (
    input wire logic mclk,
    output logic reqValid,
    output var smwd_pkg::smwd_source_t reqSource,
    output logic [31:0] reqAddr,
    output logic reqWrite,
    output logic reqCodeFetch,
    output logic reqMgmtMode,
    output logic reqTypeBit1,
    output logic reqTranslated,
    output logic reqTableFetch,
    output logic reqTiled
);
    import smwd_pkg::*;
    initial begin
        reqValid = 1'b0;
        reqSource = SMWD_SRC_CPU;
        reqAddr = 32'h0;
        {reqWrite, reqCodeFetch, reqMgmtMode, reqTranslated, reqTableFetch, reqTiled} = 6'h0;
        reqTypeBit1 = 1'b1;
    end
    // Flags: 0 write, 1 code fetch, 2 mgmt mode, 3 writeback, 4 translated, 5 table fetch
    task automatic send(input smwd_source_t s, input logic [31:0] a, input logic [5:0] f);
        @(posedge mclk);
        reqValid <= 1'b1;
        reqSource <= s;
        reqAddr <= a;
        {reqTableFetch, reqTranslated, reqMgmtMode, reqCodeFetch, reqWrite} <= {f[5:4], f[2:0]};
        reqTypeBit1 <= ~f[3];
        // Flag 3 marks a writeback from the processor and a tiled write from a link
        reqTiled <= f[3] && (s != SMWD_SRC_CPU);
        @(posedge mclk);
        reqValid <= 1'b0;
        // A released bus must not keep showing the last address
        reqAddr <= ~a;
    endtask : send
endmodule : smwd_req_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the window decoder, registers over Avalon-MM.
// Assumes one clock, clock enable held high, and the requester model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "smwd_params.svh"
module testbench;
    import smwd_pkg::*;
    localparam logic [5:0] W = 6'h01, CF = 6'h02, MM = 6'h04, WB = 6'h08, TR = 6'h10, TF = 6'h20;
    localparam smwd_source_t C = SMWD_SRC_CPU, GL = SMWD_SRC_GFXLINK, SL = SMWD_SRC_SBLINK;
    localparam smwd_target_t DR = SMWD_TGT_DRAM, GX = SMWD_TGT_GFX, GK = SMWD_TGT_GFXLINK;
    localparam smwd_target_t SB = SMWD_TGT_SBLINK, AB = SMWD_TGT_ABORT;
    localparam logic [31:0] RD = `SMWD_REDIRECT_ADDR;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] avAddress = 5'h00;
    logic avRead = 1'b0;
    logic avWrite = 1'b0;
    logic [31:0] avWritedata = 32'h0;
    logic [31:0] avReaddata, reqAddr, decAddr;
    logic avWaitrequest, reqValid, reqWrite, reqCodeFetch, reqMgmtMode, reqTypeBit1;
    logic reqTranslated, reqTableFetch, reqTiled, decValid, decByteEnOff, decUnsupported;
    logic decViolation;
    smwd_source_t reqSource;
    smwd_target_t decTarget;
    int fail_count = 0;
    int cmp_count = 0;
    always #4 mclk = ~mclk;
    smwd_decode u_smwd_decode (.mclk(mclk), .reset(reset), .clkEnable(1'b1),
        .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata),
        .avByteenable(4'hF), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest),
        .reqValid(reqValid), .reqSource(reqSource), .reqAddr(reqAddr), .reqWrite(reqWrite),
        .reqCodeFetch(reqCodeFetch), .reqMgmtMode(reqMgmtMode), .reqTypeBit1(reqTypeBit1),
        .reqTranslated(reqTranslated), .reqTableFetch(reqTableFetch), .reqTiled(reqTiled),
        .decValid(decValid), .decTarget(decTarget), .decAddr(decAddr),
        .decByteEnOff(decByteEnOff), .decUnsupported(decUnsupported), .decViolation(decViolation));
    smwd_req_model u_smwd_req_model (.mclk(mclk), .reqValid(reqValid), .reqSource(reqSource),
        .reqAddr(reqAddr), .reqWrite(reqWrite), .reqCodeFetch(reqCodeFetch),
        .reqMgmtMode(reqMgmtMode), .reqTypeBit1(reqTypeBit1), .reqTranslated(reqTranslated),
        .reqTableFetch(reqTableFetch), .reqTiled(reqTiled));
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic flag(input logic s, input logic e);
        check({31'h0, s}, {31'h0, e});
    endtask : flag
    // Bus access: request held until the edge that sees waitrequest low
    task automatic acc(input logic [4:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avAddress <= a;
        avWritedata <= d;
        avWrite <= wr;
        avRead <= ~wr;
        // Waitrequest is registered, so its level at the fall is what the next rise samples
        @(negedge mclk);
        while (avWaitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                fail_count++;
                final_report();
            end
            @(negedge mclk);
        end
        @(posedge mclk);
        if (!wr) begin
            check(avReaddata, d);
        end
        avWrite <= 1'b0;
        avRead <= 1'b0;
    endtask : acc
    task automatic dec(input smwd_source_t s, input logic [31:0] a, input logic [5:0] f,
        input smwd_target_t t, input logic [31:0] ea);
        u_smwd_req_model.send(s, a, f);
        #1;
        flag(decValid, 1'b1);
        check({29'h0, decTarget}, {29'h0, t});
        if (t != AB) begin
            check(decAddr, ea);
        end
    endtask : dec
    task automatic sc_windows();
        dec(C, 32'hE0000010, 6'h0, GX, 32'hE0000010);
        dec(C, 32'hDFF00000, W, GX, 32'hDFF00000);
        dec(C, 32'hE0100000, 6'h0, GX, 32'hE0100000);
        dec(C, 32'h3F00000, 6'h0, DR, 32'h3F00000);
    endtask : sc_windows
    task automatic sc_legacy();
        dec(C, 32'hA0000, MM, SB, 32'hA0000);
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h1);
        dec(C, 32'hBFFFC, MM, DR, 32'hBFFFC);
        dec(C, 32'hA0000, 6'h0, SB, 32'hA0000);
        dec(GL, 32'hA0000, MM, AB, 32'h0);
        flag(decUnsupported, 1'b1);
        dec(C, 32'hA0000, W | WB, DR, 32'hA0000);
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h9);
        dec(C, 32'hA0000, 6'h0, DR, 32'hA0000);
    endtask : sc_legacy
    task automatic sc_high();
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h43);
        dec(C, 32'hFEDBFFFC, MM, DR, 32'hBFFFC);
        dec(C, 32'hFEDA0000, 6'h0, AB, 32'h0);
        dec(C, 32'hA0000, MM, GK, 32'hA0000);
        acc(`SMWD_OFS_CTRL, 1'b1, 32'hC3);
        dec(C, 32'hB0000, MM, SB, 32'hB0000);
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h41);
        dec(C, 32'hFEDA0000, MM, SB, 32'hFEDA0000);
    endtask : sc_high
    task automatic sc_top_mgmt_segment();
        logic [31:0] b;
        int sz[3] = '{1, 2, 8};
        for (int k = 0; k < 3; k++) begin
            b = (32'h3F - sz[k]) << 20;
            acc(`SMWD_OFS_CTRL, 1'b1, {22'h0, k[1:0], 8'h05});
            dec(C, b, MM, DR, b);
            dec(C, b, 6'h0, AB, b);
            dec(C, b - 32'h4, 6'h0, DR, b - 32'h4);
        end
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h15);
        dec(C, 32'h3E00000, MM, SB, 32'h3E00000);
        dec(C, 32'hA0000, MM | CF, DR, 32'hA0000);
        dec(C, 32'hA0000, TF, DR, RD);
        dec(C, 32'h3E00000, TF, DR, RD);
        dec(C, 32'h3DFFFFC, TF, DR, 32'h3DFFFFC);
        flag(decViolation, 1'b0);
    endtask : sc_top_mgmt_segment
    task automatic sc_xlate();
        dec(SMWD_SRC_GFXENGINE, 32'hA0000, TR | W, DR, RD);
        flag(decByteEnOff, 1'b1);
        flag(decViolation, 1'b1);
        dec(SL, 32'hD0000100, 6'h0, DR, RD);
        flag(decUnsupported, 1'b1);
        dec(SL, 32'hA0000, TR | W, DR, RD);
        flag(decByteEnOff, 1'b1);
        dec(SL, 32'hD0000100, W | WB, DR, RD);
        flag(decByteEnOff, 1'b1);
        dec(GL, 32'hD0000100, W, GX, 32'hD0000100);
        flag(decByteEnOff, 1'b0);
        dec(SMWD_SRC_GFXENGINE, 32'h3D00000, TR, DR, 32'h3D00000);
        flag(decViolation, 1'b0);
        acc(`SMWD_OFS_STATUS, 1'b0, 32'h1);
        acc(`SMWD_OFS_STATUS, 1'b1, 32'h1);
        acc(`SMWD_OFS_STATUS, 1'b0, 32'h0);
    endtask : sc_xlate
    task automatic sc_shadow();
        acc(`SMWD_OFS_SHADOW, 1'b1, 32'h00020001);
        dec(C, 32'hC0000, 6'h0, DR, 32'hC0000);
        dec(C, 32'hC0000, W, SB, 32'hC0000);
        dec(C, 32'hC4000, W, DR, 32'hC4000);
    endtask : sc_shadow
    task automatic sc_lock();
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h29);
        dec(C, 32'hA0000, 6'h0, SB, 32'hA0000);
        acc(`SMWD_OFS_CTRL, 1'b1, 32'h0);
        acc(`SMWD_OFS_CTRL, 1'b0, 32'h29);
        dec(C, 32'hA0000, MM, DR, 32'hA0000);
    endtask : sc_lock
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        sc_windows();
        sc_legacy();
        sc_high();
        sc_top_mgmt_segment();
        sc_xlate();
        sc_shadow();
        // Lock holds until reset, so it runs last
        sc_lock();
        final_report();
    end
endmodule : testbench
`default_nettype wire
